// >>> common/bdp_pkg.sv
// Purpose: Shared constants and types for the background debug port.
// Assumes: Ticks are periods of the selected debug clock, derived from core_clk.
// Notes: Command codes and tick counts are block-local choices.
package bdp_pkg;

  // Positions in the debug register window.
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_CCR_HOLD = 4'h6;
  localparam logic [3:0] OFF_INR = 4'h7;
  localparam logic [3:0] OFF_ZERO_LO = 4'h8;
  localparam logic [3:0] OFF_ZERO_HI = 4'h9;

  // Status register bit positions, and the low bit of the base in INR.
  localparam int BIT_EN = 7;
  localparam int BIT_ACT = 6;
  localparam int BIT_TAG = 5;
  localparam int BIT_SDV = 4;
  localparam int BIT_TRACE = 3;
  localparam int BIT_CLKSW = 2;
  localparam int BIT_UNSEC = 1;
  localparam int INR_LSB = 3;

  // Values after reset.
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] HOLD_RESET = 8'h00;

  // Hardware commands, nine in all.
  localparam logic [7:0] CMD_BACKGROUND = 8'h80;
  localparam logic [7:0] CMD_ACK_ENABLE = 8'h81;
  localparam logic [7:0] CMD_ACK_DISABLE = 8'h82;
  localparam logic [7:0] CMD_READ_DEBUG_REGISTER_CMD = 8'h83;
  localparam logic [7:0] CMD_WRITE_DEBUG_REGISTER_CMD = 8'h84;
  localparam logic [7:0] CMD_READ_BYTE = 8'h85;
  localparam logic [7:0] CMD_WRITE_BYTE = 8'h86;
  localparam logic [7:0] CMD_READ_WORD = 8'h87;
  localparam logic [7:0] CMD_WRITE_WORD = 8'h88;
  // Firmware commands occupy codes 0x00 up to this one, fifteen in all.
  localparam logic [7:0] CMD_FW_LAST = 8'h0E;

  // Serial frame lengths in bits.
  localparam logic [5:0] LEN_CMD = 6'h08;
  localparam logic [5:0] LEN_ADDR8 = 6'h10;
  localparam logic [5:0] LEN_ADDR16 = 6'h18;
  localparam logic [5:0] LEN_WR_BYTE = 6'h20;
  localparam logic [5:0] LEN_WR_WORD = 6'h28;

  // Register space that stays reachable while secured.
  localparam logic [15:0] REG_SPACE_END = 16'h0400;

  // Bit timing in debug clock ticks.
  localparam logic [9:0] BIT_SAMPLE_TICKS = 10'h00A;
  localparam logic [9:0] BIT_DRIVE_TICKS = 10'h00D;
  localparam logic [9:0] SYNC_REQ_TICKS = 10'h080;
  localparam logic [9:0] SYNC_DLY_TICKS = 10'h010;
  localparam logic [9:0] SYNC_END_TICKS = 10'h090;
  localparam logic [9:0] ACK_DLY_TICKS = 10'h010;
  localparam logic [9:0] ACK_END_TICKS = 10'h020;
  localparam logic [9:0] TICK_MAX = 10'h3FF;
  // Core cycles after reset release before the strap is read.
  localparam logic [1:0] CAPTURE_CYCLES = 2'h2;

  // Serial engine states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_EXEC = 3'b010,
    ST_BUS = 3'b011,
    ST_FW = 3'b100,
    ST_ACK = 3'b101,
    ST_TX = 3'b110,
    ST_SYNC = 3'b111
  } bdp_state_type;

endpackage

// >>> common/bdp_regs_if.sv
// Purpose: Carrier between the serial engine and the holding memory.
// Assumes: One write or read address per core_clk cycle.
// Notes: Read data arrive one cycle after the address.
interface bdp_regs_if;
  logic wr_en;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output wr_en, output addr, output wdata, input rdata);
  modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface

// >>> core/bdp_hold_mem.sv
// Purpose: Holding bytes of the debug register window.
// Assumes: Addresses come from the serial engine on the same clock.
// Notes: Read data leave through a register, one cycle late.
module bdp_hold_mem #(
  parameter int DEPTH = 16
) (
  // Clock, reset and freeze.
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Engine side.
  bdp_regs_if.mem regs
);

  logic [7:0] mem_reg [DEPTH];
  logic [7:0] rdata_reg;

  // Stores written bytes and registers the read byte.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= bdp_pkg::HOLD_RESET;
      end
      rdata_reg <= bdp_pkg::HOLD_RESET;
    end else if (clk_en) begin
      if (regs.wr_en) begin
        mem_reg[regs.addr] <= regs.wdata;
      end
      rdata_reg <= mem_reg[regs.addr];
    end
  end

  assign regs.rdata = rdata_reg;

endmodule

// >>> core/bdp_core.sv
// Purpose: Background debug port behind one open-drain wire.
// Assumes: The host starts every bit with a falling edge on the wire.
// Notes: Memory commands steal cycles only when bus_free is high.
module bdp_core (
  // Clock, reset and freeze.
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Background wire, open drain.
  input wire logic background_wire_in,
  output logic background_wire_out,
  output logic background_wire_oe,
  // Chip mode and security state.
  input wire logic special_periph_sel,
  input wire logic secure,
  input wire logic erase_fail,
  input wire logic [3:0] reg_base,
  output logic special_mode,
  // Stolen-cycle bus port.
  input wire logic bus_free,
  input wire logic [15:0] bus_rdata,
  output logic bus_req,
  output logic bus_write,
  output logic bus_byte,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_wdata,
  // Firmware side.
  input wire logic debug_enter_req,
  input wire logic fw_done,
  input wire logic fw_exit,
  output logic fw_cmd_valid,
  output logic [3:0] fw_cmd_code,
  output logic debug_enable_flag,
  output logic debug_active_flag,
  // Instruction tagging.
  input wire logic tag_high_input,
  input wire logic tag_low_input,
  input wire logic external_bus_clock,
  input wire logic low_byte_strobe,
  output logic tag_high_mark,
  output logic tag_low_mark
);

  // Bits the host must send for a command, zero when it is unknown.
  function automatic logic [5:0] rx_bits(input logic [7:0] cmd);
    case (cmd)
      bdp_pkg::CMD_BACKGROUND, bdp_pkg::CMD_ACK_ENABLE,
      bdp_pkg::CMD_ACK_DISABLE: rx_bits = bdp_pkg::LEN_CMD;
      bdp_pkg::CMD_READ_DEBUG_REGISTER_CMD: rx_bits = bdp_pkg::LEN_ADDR8;
      bdp_pkg::CMD_WRITE_DEBUG_REGISTER_CMD, bdp_pkg::CMD_READ_BYTE,
      bdp_pkg::CMD_READ_WORD: rx_bits = bdp_pkg::LEN_ADDR16;
      bdp_pkg::CMD_WRITE_BYTE: rx_bits = bdp_pkg::LEN_WR_BYTE;
      bdp_pkg::CMD_WRITE_WORD: rx_bits = bdp_pkg::LEN_WR_WORD;
      default: rx_bits = (cmd <= bdp_pkg::CMD_FW_LAST) ? bdp_pkg::LEN_CMD : 6'h00;
    endcase
  endfunction

  // State after a command completes: handshake first, then any reply.
  function automatic bdp_pkg::bdp_state_type after_done(input logic ack, input logic reply);
    if (ack) begin
      after_done = bdp_pkg::ST_ACK;
    end else if (reply) begin
      after_done = bdp_pkg::ST_TX;
    end else begin
      after_done = bdp_pkg::ST_IDLE;
    end
  endfunction

  // Pin group: synchronisers, strap capture and tagging.
  logic [3:0] s1_reg, s2_reg;
  logic [1:0] prev_reg, prev_next;
  logic [1:0] cap_reg, cap_next;
  logic done_reg, done_next, special_reg, special_next, periph_reg, periph_next;
  logic tag_hi_reg, tag_hi_next, tag_lo_reg, tag_lo_next;
  logic [7:0] inr_reg, inr_next;
  logic wire_s, external_bus_clock_s, cap_pulse, fall;
  // Engine group.
  bdp_pkg::bdp_state_type st_reg, st_next;
  logic [9:0] tmr_reg, tmr_next, low_reg, low_next;
  logic [5:0] rxc_reg, rxc_next, need_reg, need_next, cnt1, nneed;
  logic [39:0] sh_reg, sh_next, shin;
  logic [7:0] cmd_reg, cmd_next, rd_mux, status_vec;
  logic [15:0] tx_reg, tx_next, addr16;
  logic [4:0] txl_reg, txl_next;
  logic oe_reg, oe_next, out_reg, acken_reg, acken_next, pre_reg, pre_next, tick;
  logic en_reg, en_next, act_reg, act_next, act_set, act_clr;
  logic tag_reg, tag_next, sdv_reg, sdv_next, trace_reg, trace_next, clksw_reg, clksw_next;
  logic breq_reg, breq_next, bwr_reg, bwr_next, bbyte_reg, bbyte_next;
  logic [15:0] baddr_reg, baddr_next, bwdata_reg, bwdata_next;
  logic fwv_reg, fwv_next, mem_ok, is_read;
  logic [3:0] fwc_reg, fwc_next, reg_addr;
  bdp_regs_if regs ();

  bdp_hold_mem #(.DEPTH(16)) u_hold (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .regs(regs)
  );

  assign wire_s = s2_reg[3];
  assign external_bus_clock_s = s2_reg[2];

  // Strap capture, read-only position register and tag marks.
  always_comb begin
    prev_next = {wire_s, external_bus_clock_s};
    cap_next = cap_reg;
    done_next = done_reg;
    special_next = special_reg;
    periph_next = periph_reg;
    cap_pulse = 1'b0;
    inr_next = {1'b0, reg_base, 3'h0};
    if (!done_reg) begin
      cap_next = cap_reg + 2'h1;
      if (cap_reg == bdp_pkg::CAPTURE_CYCLES) begin
        cap_pulse = 1'b1;
        done_next = 1'b1;
        special_next = ~wire_s;
        periph_next = ~wire_s & special_periph_sel;
      end
    end
    tag_hi_next = prev_reg[0] & ~external_bus_clock_s & tag_reg & ~s2_reg[1];
    tag_lo_next = prev_reg[0] & ~external_bus_clock_s & tag_reg & low_byte_strobe & ~s2_reg[0];
  end

  // Registers the pin group; the synchronisers idle high like the wire.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 4'hF;
      s2_reg <= 4'hF;
      prev_reg <= 2'h3;
      cap_reg <= 2'h0;
      done_reg <= 1'b0;
      special_reg <= 1'b0;
      periph_reg <= 1'b0;
      tag_hi_reg <= 1'b0;
      tag_lo_reg <= 1'b0;
      inr_reg <= 8'h00;
    end else if (clk_en) begin
      s1_reg <= {background_wire_in, external_bus_clock, tag_high_input, tag_low_input};
      s2_reg <= s1_reg;
      prev_reg <= prev_next;
      cap_reg <= cap_next;
      done_reg <= done_next;
      special_reg <= special_next;
      periph_reg <= periph_next;
      tag_hi_reg <= tag_hi_next;
      tag_lo_reg <= tag_lo_next;
      inr_reg <= inr_next;
    end
  end

  // Register window decode and read selection.
  assign reg_addr = (cmd_reg == bdp_pkg::CMD_WRITE_DEBUG_REGISTER_CMD) ? sh_reg[11:8] : sh_reg[3:0];
  assign status_vec = {en_reg, act_reg, tag_reg, sdv_reg, trace_reg, clksw_reg, ~secure, 1'b0};
  assign regs.addr = reg_addr;
  assign regs.wdata = sh_reg[7:0];
  always_comb begin
    case (reg_addr)
      bdp_pkg::OFF_STATUS: rd_mux = status_vec;
      bdp_pkg::OFF_INR: rd_mux = inr_reg;
      bdp_pkg::OFF_ZERO_LO, bdp_pkg::OFF_ZERO_HI: rd_mux = 8'h00;
      default: rd_mux = regs.rdata;
    endcase
  end

  // Secured parts reach only the register space, and only when so allowed.
  assign addr16 = (cmd_reg == bdp_pkg::CMD_WRITE_BYTE) ? sh_reg[23:8] :
                  (cmd_reg == bdp_pkg::CMD_WRITE_WORD) ? sh_reg[31:16] : sh_reg[15:0];
  assign mem_ok = ~secure | (special_reg & ~periph_reg & erase_fail &
                  (addr16 < bdp_pkg::REG_SPACE_END));
  assign is_read = (cmd_reg == bdp_pkg::CMD_READ_BYTE) | (cmd_reg == bdp_pkg::CMD_READ_WORD);
  assign tick = clksw_reg | pre_reg;
  assign fall = prev_reg[1] & ~wire_s;
  assign cnt1 = rxc_reg + 6'h01;
  assign shin = {sh_reg[38:0], wire_s};
  assign nneed = (cnt1 == bdp_pkg::LEN_CMD) ? rx_bits(shin[7:0]) : need_reg;

  // Serial engine, status flags and stolen-cycle requests.
  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg;
    rxc_next = rxc_reg;
    need_next = need_reg;
    sh_next = sh_reg;
    cmd_next = cmd_reg;
    tx_next = tx_reg;
    txl_next = txl_reg;
    oe_next = oe_reg;
    acken_next = acken_reg;
    pre_next = ~pre_reg;
    en_next = en_reg;
    tag_next = tag_reg;
    sdv_next = sdv_reg;
    trace_next = trace_reg;
    clksw_next = clksw_reg;
    breq_next = breq_reg;
    bwr_next = bwr_reg;
    bbyte_next = bbyte_reg;
    baddr_next = baddr_reg;
    bwdata_next = bwdata_reg;
    fwv_next = 1'b0;
    fwc_next = fwc_reg;
    act_set = debug_enter_req & en_reg;
    act_clr = fw_exit;
    regs.wr_en = 1'b0;
    // Host low time, own drive excluded.
    low_next = (wire_s | oe_reg) ? 10'h000 :
               (tick && low_reg != bdp_pkg::TICK_MAX) ? low_reg + 10'h001 : low_reg;
    if (fall && (st_reg == bdp_pkg::ST_IDLE || st_reg == bdp_pkg::ST_RX ||
        st_reg == bdp_pkg::ST_TX)) begin
      tmr_next = 10'h000;
    end else if (tick && tmr_reg != bdp_pkg::TICK_MAX) begin
      tmr_next = tmr_reg + 10'h001;
    end
    if (cap_pulse && special_next) begin
      en_next = 1'b1;
      act_set = 1'b1;
    end
    if (done_reg && !prev_reg[1] && wire_s && low_reg >= bdp_pkg::SYNC_REQ_TICKS &&
        st_reg != bdp_pkg::ST_SYNC) begin
      st_next = bdp_pkg::ST_SYNC;
      tmr_next = 10'h000;
      oe_next = 1'b0;
      breq_next = 1'b0;
    end else begin
      case (st_reg)
        bdp_pkg::ST_IDLE: begin
          if (fall && done_reg) begin
            st_next = bdp_pkg::ST_RX;
            rxc_next = 6'h00;
            need_next = bdp_pkg::LEN_CMD;
          end
        end
        bdp_pkg::ST_RX: begin
          if (tick && tmr_reg == bdp_pkg::BIT_SAMPLE_TICKS) begin
            sh_next = shin;
            rxc_next = cnt1;
            need_next = nneed;
            if (cnt1 == bdp_pkg::LEN_CMD) begin
              cmd_next = shin[7:0];
            end
            if (nneed == 6'h00) begin
              st_next = bdp_pkg::ST_IDLE;
            end else if (cnt1 == nneed) begin
              st_next = bdp_pkg::ST_EXEC;
            end
          end
        end
        bdp_pkg::ST_EXEC: begin
          tmr_next = 10'h000;
          txl_next = 5'h00;
          case (cmd_reg)
            bdp_pkg::CMD_BACKGROUND: begin
              act_set = act_set | en_reg;
              st_next = after_done(acken_reg, 1'b0);
            end
            bdp_pkg::CMD_ACK_ENABLE, bdp_pkg::CMD_ACK_DISABLE: begin
              acken_next = (cmd_reg == bdp_pkg::CMD_ACK_ENABLE);
              st_next = after_done(cmd_reg == bdp_pkg::CMD_ACK_ENABLE, 1'b0);
            end
            bdp_pkg::CMD_READ_DEBUG_REGISTER_CMD: st_next = bdp_pkg::ST_BUS;
            bdp_pkg::CMD_WRITE_DEBUG_REGISTER_CMD: begin
              regs.wr_en = 1'b1;
              if (reg_addr == bdp_pkg::OFF_STATUS) begin
                en_next = sh_reg[bdp_pkg::BIT_EN];
                tag_next = sh_reg[bdp_pkg::BIT_TAG];
                sdv_next = sh_reg[bdp_pkg::BIT_SDV];
                trace_next = sh_reg[bdp_pkg::BIT_TRACE];
                clksw_next = sh_reg[bdp_pkg::BIT_CLKSW];
                act_clr = act_clr | (periph_reg & ~sh_reg[bdp_pkg::BIT_ACT]);
              end
              st_next = after_done(acken_reg, 1'b0);
            end
            bdp_pkg::CMD_READ_BYTE, bdp_pkg::CMD_READ_WORD, bdp_pkg::CMD_WRITE_BYTE,
            bdp_pkg::CMD_WRITE_WORD: begin
              if (mem_ok) begin
                breq_next = 1'b1;
                baddr_next = addr16;
                bwdata_next = (cmd_reg == bdp_pkg::CMD_WRITE_WORD) ? sh_reg[15:0] :
                              {8'h00, sh_reg[7:0]};
                bwr_next = ~is_read;
                bbyte_next = (cmd_reg == bdp_pkg::CMD_READ_BYTE) |
                             (cmd_reg == bdp_pkg::CMD_WRITE_BYTE);
                st_next = bdp_pkg::ST_BUS;
              end else begin
                tx_next = 16'h0000;
                txl_next = !is_read ? 5'h00 :
                           (cmd_reg == bdp_pkg::CMD_READ_BYTE) ? 5'h08 : 5'h10;
                st_next = after_done(acken_reg, is_read);
              end
            end
            default: begin
              if (act_reg) begin
                fwv_next = 1'b1;
                fwc_next = cmd_reg[3:0];
                st_next = bdp_pkg::ST_FW;
              end else begin
                st_next = bdp_pkg::ST_IDLE;
              end
            end
          endcase
          if (after_done(acken_reg, 1'b1) == bdp_pkg::ST_TX && st_next == bdp_pkg::ST_TX) begin
            tmr_next = bdp_pkg::TICK_MAX;
          end
        end
        bdp_pkg::ST_BUS: begin
          tmr_next = 10'h000;
          if (cmd_reg == bdp_pkg::CMD_READ_DEBUG_REGISTER_CMD) begin
            tx_next = {rd_mux, 8'h00};
            txl_next = 5'h08;
            st_next = after_done(acken_reg, 1'b1);
          end else if (breq_reg && bus_free) begin
            breq_next = 1'b0;
            tx_next = bbyte_reg ? {bus_rdata[7:0], 8'h00} : bus_rdata;
            txl_next = !is_read ? 5'h00 : bbyte_reg ? 5'h08 : 5'h10;
            st_next = after_done(acken_reg, is_read);
          end
          if (st_next == bdp_pkg::ST_TX) begin
            tmr_next = bdp_pkg::TICK_MAX;
          end
        end
        bdp_pkg::ST_FW: begin
          if (fw_done) begin
            tmr_next = 10'h000;
            st_next = after_done(acken_reg, 1'b0);
          end
        end
        bdp_pkg::ST_ACK: begin
          oe_next = (tmr_reg >= bdp_pkg::ACK_DLY_TICKS);
          if (tmr_reg >= bdp_pkg::ACK_END_TICKS) begin
            oe_next = 1'b0;
            tmr_next = bdp_pkg::TICK_MAX;
            st_next = (txl_reg != 5'h00) ? bdp_pkg::ST_TX : bdp_pkg::ST_IDLE;
          end
        end
        bdp_pkg::ST_TX: begin
          if (fall) begin
            oe_next = ~tx_reg[15];
          end
          if (tick && tmr_reg == bdp_pkg::BIT_DRIVE_TICKS) begin
            oe_next = 1'b0;
            tx_next = {tx_reg[14:0], 1'b0};
            txl_next = txl_reg - 5'h01;
            if (txl_reg == 5'h01) begin
              st_next = bdp_pkg::ST_IDLE;
            end
          end
        end
        bdp_pkg::ST_SYNC: begin
          oe_next = (tmr_reg >= bdp_pkg::SYNC_DLY_TICKS);
          if (tmr_reg >= bdp_pkg::SYNC_END_TICKS) begin
            oe_next = 1'b0;
            st_next = bdp_pkg::ST_IDLE;
          end
        end
        default: st_next = bdp_pkg::ST_IDLE;
      endcase
    end
    // Setting wins over a clear in the same cycle.
    act_next = act_set ? 1'b1 : (act_clr ? 1'b0 : act_reg);
  end

  // Registers the engine group.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= bdp_pkg::ST_IDLE;
      tmr_reg <= 10'h000;
      low_reg <= 10'h000;
      rxc_reg <= 6'h00;
      need_reg <= 6'h00;
      sh_reg <= 40'h00_0000_0000;
      cmd_reg <= 8'h00;
      tx_reg <= 16'h0000;
      txl_reg <= 5'h00;
      oe_reg <= 1'b0;
      out_reg <= 1'b0;
      acken_reg <= 1'b0;
      pre_reg <= 1'b0;
      en_reg <= bdp_pkg::STATUS_RESET[bdp_pkg::BIT_EN];
      act_reg <= bdp_pkg::STATUS_RESET[bdp_pkg::BIT_ACT];
      tag_reg <= bdp_pkg::STATUS_RESET[bdp_pkg::BIT_TAG];
      sdv_reg <= bdp_pkg::STATUS_RESET[bdp_pkg::BIT_SDV];
      trace_reg <= bdp_pkg::STATUS_RESET[bdp_pkg::BIT_TRACE];
      clksw_reg <= bdp_pkg::STATUS_RESET[bdp_pkg::BIT_CLKSW];
      breq_reg <= 1'b0;
      bwr_reg <= 1'b0;
      bbyte_reg <= 1'b0;
      baddr_reg <= 16'h0000;
      bwdata_reg <= 16'h0000;
      fwv_reg <= 1'b0;
      fwc_reg <= 4'h0;
    end else if (clk_en) begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      low_reg <= low_next;
      rxc_reg <= rxc_next;
      need_reg <= need_next;
      sh_reg <= sh_next;
      cmd_reg <= cmd_next;
      tx_reg <= tx_next;
      txl_reg <= txl_next;
      oe_reg <= oe_next;
      out_reg <= 1'b0;
      acken_reg <= acken_next;
      pre_reg <= pre_next;
      en_reg <= en_next;
      act_reg <= act_next;
      tag_reg <= tag_next;
      sdv_reg <= sdv_next;
      trace_reg <= trace_next;
      clksw_reg <= clksw_next;
      breq_reg <= breq_next;
      bwr_reg <= bwr_next;
      bbyte_reg <= bbyte_next;
      baddr_reg <= baddr_next;
      bwdata_reg <= bwdata_next;
      fwv_reg <= fwv_next;
      fwc_reg <= fwc_next;
    end
  end

  // Outputs straight from flip-flops.
  assign background_wire_out = out_reg;
  assign background_wire_oe = oe_reg;
  assign special_mode = special_reg;
  assign bus_req = breq_reg;
  assign bus_write = bwr_reg;
  assign bus_byte = bbyte_reg;
  assign bus_addr = baddr_reg;
  assign bus_wdata = bwdata_reg;
  assign fw_cmd_valid = fwv_reg;
  assign fw_cmd_code = fwc_reg;
  assign debug_enable_flag = en_reg;
  assign debug_active_flag = act_reg;
  assign tag_high_mark = tag_hi_reg;
  assign tag_low_mark = tag_lo_reg;

endmodule

// >>> tb/bdp_properties.sv
// Purpose: Port checks for the background debug port.
// Assumes: One clock domain with reset rst_n.
// Notes: Bound to every bdp_core.
module bdp_properties (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports.
  input wire logic background_wire_oe,
  input wire logic special_mode,
  input wire logic secure,
  input wire logic erase_fail,
  input wire logic bus_free,
  input wire logic bus_req,
  input wire logic [15:0] bus_addr,
  input wire logic fw_cmd_valid,
  input wire logic debug_enable_flag,
  input wire logic debug_active_flag,
  input wire logic low_byte_strobe,
  input wire logic tag_low_mark
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks run on the core clock.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // A stalled bus request keeps its address until taken.
  sequence s_stall;
    bus_req && !bus_free;
  endsequence
  sequence s_held;
    bus_req && $stable(bus_addr);
  endsequence
  property p_stall;
    s_stall |=> s_held;
  endproperty
  a_stall: assert property (p_stall) else $error("bus request lost");
  property p_take;
    bus_req && bus_free |=> !bus_req;
  endproperty
  a_take: assert property (p_take) else $error("bus request kept");
  property p_sec;
    $rose(bus_req) |-> !secure || (special_mode && erase_fail && bus_addr < 16'h0400);
  endproperty
  a_sec: assert property (p_sec) else $error("secured access");
  property p_fw;
    fw_cmd_valid |-> debug_active_flag ##1 !fw_cmd_valid;
  endproperty
  a_fw: assert property (p_fw) else $error("firmware while inactive");
  property p_act;
    $rose(debug_active_flag) |-> debug_enable_flag;
  endproperty
  a_act: assert property (p_act) else $error("active while disabled");
  property p_mode;
    $changed(special_mode) |-> $rose(special_mode);
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed");
  property p_strap;
    $rose(rst_n) |-> !background_wire_oe [*4];
  endproperty
  a_strap: assert property (p_strap) else $error("wire driven at strap");
  property p_tag;
    tag_low_mark |-> low_byte_strobe;
  endproperty
  a_tag: assert property (p_tag) else $error("low tag without strobe");
endmodule

bind bdp_core bdp_properties chk_u (.*);

// >>> tb/bdp_host_model.sv
// Purpose: Host side of the one-wire debug link.
// Assumes: Debug clock ticks every second core cycle.
// Notes: Bit period is 40 core cycles, MSB first.
module bdp_host_model (
  // Clock.
  input wire logic core_clk,
  // Shared wire.
  input wire logic wire_lvl,
  output logic host_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wire released at start.
  initial host_low = 1'h0;
  // Sends bytes; a short low is a 1, a long low a 0.
  task automatic send(input logic [7:0] q[$]);
    foreach (q[k]) begin
      for (int i = 7; i >= 0; i--) begin
        @(posedge core_clk);
        host_low <= 1'h1;
        repeat (q[k][i] ? 4 : 30) @(posedge core_clk);
        host_low <= 1'h0;
        repeat (q[k][i] ? 35 : 9) @(posedge core_clk);
      end
    end
  endtask
  // Holds the wire low for a number of cycles, as a sync request.
  task automatic hold_low(input int n);
    @(posedge core_clk);
    host_low <= 1'h1;
    repeat (n) @(posedge core_clk);
    host_low <= 1'h0;
  endtask
  // Reads one byte, sampling before the device lets go.
  task automatic recv(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      host_low <= 1'h1;
      repeat (4) @(posedge core_clk);
      host_low <= 1'h0;
      repeat (10) @(posedge core_clk);
      d[i] = wire_lvl;
      repeat (25) @(posedge core_clk);
    end
  endtask
endmodule

// >>> tb/background_debug_port_tb_top.sv
// Purpose: Self-checking bench for the background debug port.
// Assumes: Handshake off except in t_link; debug clock ticks every second cycle.
// Notes: Wire is pulled up; host, strap and device pull it low.
module background_debug_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n = 1'h0, clk_en = 1'h1, strap_low = 1'h1, host_low;
  logic special_periph_sel = 1'h0, secure = 1'h0, erase_fail = 1'h0, bus_free = 1'h0;
  logic debug_enter_req = 1'h0, fw_done = 1'h1, fw_exit = 1'h0, low_byte_strobe = 1'h0;
  logic tag_high_input = 1'h1, tag_low_input = 1'h1, external_bus_clock = 1'h1;
  logic [3:0] reg_base = 4'h3;
  logic [15:0] bus_rdata = 16'h0000;
  logic background_wire_in, background_wire_out, background_wire_oe, special_mode, bus_req;
  logic bus_write, bus_byte, fw_cmd_valid, debug_enable_flag, debug_active_flag;
  logic tag_high_mark, tag_low_mark;
  logic [15:0] bus_addr, bus_wdata;
  logic [3:0] fw_cmd_code;
  int err_total = 0, compares = 0, fw_n = 0, bus_n = 0, th_n = 0, tl_n = 0, oe_n = 0;
  // Open-drain wire with pull-up.
  assign background_wire_in = !(host_low || strap_low || background_wire_oe);
  bdp_core dut_u (.*);
  bdp_host_model host_u (.core_clk(core_clk), .wire_lvl(background_wire_in), .host_low(host_low));
  // Clock of 8 ns period.
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  // Counts pulses, cycles of device drive and taken bus requests.
  always @(posedge core_clk) begin
    fw_n += int'(fw_cmd_valid === 1'h1);
    bus_n += int'(bus_req === 1'h1 && bus_free);
    th_n += int'(tag_high_mark === 1'h1);
    tl_n += int'(tag_low_mark === 1'h1);
    oe_n += int'(background_wire_oe === 1'h1);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic strap, input logic periph);
    rst_n <= 1'h0;
    strap_low <= strap;
    special_periph_sel <= periph;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (8) @(posedge core_clk);
    strap_low <= 1'h0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic rd_bd(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] d;
    host_u.send('{8'h83, off});
    repeat (20) @(posedge core_clk);
    host_u.recv(d);
    check(d, exp);
  endtask
  task automatic t_normal;
    do_reset(1'h0, 1'h0);
    check({special_mode, debug_enable_flag, debug_active_flag}, 3'h0);
    reg_base <= 4'hA;
    rd_bd(8'h01, 8'h02);
    rd_bd(8'h07, 8'h50);
    host_u.send('{8'h03});
    repeat (40) @(posedge core_clk);
    check(16'(fw_n), 16'h0000);
    $display("normal mode test done");
  endtask
  task automatic t_special;
    do_reset(1'h1, 1'h0);
    check({special_mode, debug_enable_flag, debug_active_flag}, 3'h7);
    host_u.send('{8'h05});
    repeat (40) @(posedge core_clk);
    check(16'(fw_n), 16'h0001);
    check(fw_cmd_code, 4'h5);
    host_u.send('{8'h88, 8'h20, 8'h00, 8'hBE, 8'hEF});
    repeat (40) @(posedge core_clk);
    check({bus_req, bus_write, bus_byte}, 3'h6);
    check(bus_addr, 16'h2000);
    check(bus_wdata, 16'hBEEF);
    bus_free <= 1'h1;
    repeat (4) @(posedge core_clk);
    check(16'(bus_n), 16'h0001);
    secure <= 1'h1;
    host_u.send('{8'h86, 8'h00, 8'h10, 8'h5A});
    repeat (40) @(posedge core_clk);
    check(16'(bus_n), 16'h0001);
    erase_fail <= 1'h1;
    host_u.send('{8'h86, 8'h00, 8'h10, 8'h5A});
    repeat (40) @(posedge core_clk);
    check(16'(bus_n), 16'h0002);
    secure <= 1'h0;
    erase_fail <= 1'h0;
    bus_free <= 1'h0;
    $display("special chip test done");
  endtask
  task automatic t_periph;
    do_reset(1'h1, 1'h1);
    check(debug_active_flag, 1'h1);
    host_u.send('{8'h84, 8'h01, 8'hA0});
    repeat (40) @(posedge core_clk);
    check({debug_enable_flag, debug_active_flag}, 2'h2);
    low_byte_strobe <= 1'h1;
    tag_high_input <= 1'h0;
    tag_low_input <= 1'h0;
    repeat (4) @(posedge core_clk);
    external_bus_clock <= 1'h0;
    repeat (10) @(posedge core_clk);
    check(16'(th_n), 16'h0001);
    check(16'(tl_n), 16'h0001);
    $display("peripheral and tag test done");
  endtask
  // Handshake pulse lasts 16 ticks, sync reply 128 ticks, two cycles per tick.
  task automatic t_link;
    int o0 = oe_n;
    host_u.send('{8'h81});
    repeat (60) @(posedge core_clk);
    check(16'(oe_n - o0), 16'h0020);
    host_u.send('{8'h82});
    host_u.hold_low(300);
    repeat (320) @(posedge core_clk);
    check(16'(oe_n - o0), 16'h0120);
    check(background_wire_out, 1'h0);
    $display("handshake and sync test done");
  endtask
  // Main sequence.
  initial begin
    t_normal();
    t_special();
    t_periph();
    t_link();
    finish_test();
  end
  // Cuts a hung run short.
  initial begin
    #150000;
    err_total++;
    finish_test();
  end
endmodule
